/* i2c_slave_map.svh */
// constants for the indexed-register two-wire slave
// assumes inclusion by the package, design modules and testbench only
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH
`define DEFAULT_DEV_ADDR 7'h29
`define INDEX_WIDTH 16
`define DATA_WIDTH 8
`define BIT_COUNT_LAST 4'h7
`define BIT_COUNT_ACK 4'h8
`define BIT_COUNT_ARMED 4'hF
`define REG_DEPTH 256
`endif

/* i2c_slave_pkg.sv */
// types used by the two-wire slave module
// assumes the map header sits in the same folder
`include "i2c_slave_map.svh"
package i2c_slave_pkg;
    // phase of the byte engine, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_IDX_HI = 5'h04,
        ST_IDX_LO = 5'h08,
        ST_DATA = 5'h10
    } phase_t;
endpackage

/* pin_sync.sv */
// two-flop synchroniser with edge detection for the bus pins
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_q, s1_d; // first stage, read only by second
    logic s2_q, s2_d; // settled level
    logic s3_q, s3_d; // previous settled level
    // next values
    always_comb begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
    end
    // registers, idle bus is high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end
    assign level = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

/* reg_store.sv */
// byte-wide register store addressed by an index
// assumes one write per cycle at most
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_map.svh"
module reg_store #(
    parameter int DEPTH = `REG_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [`INDEX_WIDTH-1:0] index,
    input wire logic [`DATA_WIDTH-1:0] wr_data,
    output logic [`DATA_WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [`DATA_WIDTH-1:0] mem_q [DEPTH];
    logic [`DATA_WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] slot; // low index bits pick the slot
    assign slot = index[AW-1:0];
    // next contents
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en) begin
            mem_d[slot] = wr_data;
        end
    end
    // storage flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= mem_d[i];
            end
        end
    end
    // combinational read, caller registers it
    assign rd_data = mem_q[slot];
endmodule
`default_nettype wire

/* i2c_reg_slave.sv */
// two-wire slave giving an external master indexed access to byte registers
// assumes scl and sda arrive asynchronously; sda drive is open-drain (low only)
// Notes on behaviour
// RQ1 - answer default address unless configured otherwise
// RQ2 - each byte followed by one acknowledge slot
// RQ3 - sample data on clock rise, hold while high
// RQ4 - start and stop are data edges, clock high
// RQ5 - master opens every message with start
// RQ6 - message ends in stop or repeated start
// RQ7 - first byte is address, lsb gives direction
// RQ8 - acknowledge matching address, keep direction bit
// RQ9 - two bytes after address form index, msb first
// RQ10 - shift in byte, acknowledge, then store it
// RQ11 - read loads indexed register, shifts on fall
// RQ12 - receiver acknowledges each byte
// RQ13 - only the master ends a message
// RQ14 - index increments after every data byte (a refused read byte leaves it unchanged)
// RQ15 - master bursts until nack or stop
// RQ16 - wide registers stored msb at lowest index
// RQ17 - read uses last written index, auto-increments
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_map.svh"
module i2c_reg_slave
    import i2c_slave_pkg::*;
#(
    parameter int DEPTH = `REG_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_cfg_en,
    input wire logic [6:0] addr_cfg,
    output logic busy,
    output logic wr_strobe,
    output logic [`INDEX_WIDTH-1:0] cur_index
);
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    // pin synchronisers
    pin_sync scl_sync (
        .sys_clk(sys_clk), .rst(rst), .pin_in(scl_in),
        .level(scl_lvl), .rise(scl_rise), .fall(scl_fall)
    );
    pin_sync sda_sync (
        .sys_clk(sys_clk), .rst(rst), .pin_in(sda_in),
        .level(sda_lvl), .rise(sda_rise), .fall(sda_fall)
    );
    // framing conditions while clock high
    logic start_ev, stop_ev;
    assign start_ev = scl_lvl & sda_fall; // [RQ4] [RQ5] [RQ6]
    assign stop_ev = scl_lvl & sda_rise; // [RQ4] [RQ13]

    phase_t phase_q, phase_d; // byte engine phase
    logic [3:0] bit_q, bit_d; // bit position, 8 is ack slot
    logic [7:0] sh_q, sh_d; // serial/parallel register
    logic rd_q, rd_d; // latched direction
    logic ack_q, ack_d; // we drive ack low in slot
    logic drv_q, drv_d; // we drive read data
    logic nack_q, nack_d; // master refused the read byte
    logic [`INDEX_WIDTH-1:0] idx_q, idx_d; // current register index
    logic wr_q, wr_d; // store pulse
    logic [7:0] store_q, store_d; // byte to store
    logic [7:0] rd_data;
    logic [6:0] my_addr;

    // address in use [RQ1]
    assign my_addr = addr_cfg_en ? addr_cfg : `DEFAULT_DEV_ADDR;

    // incoming byte with the new bit appended
    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
        return {v[6:0], b};
    endfunction

    // next state of the byte engine
    always_comb begin
        phase_d = phase_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rd_d = rd_q;
        ack_d = ack_q;
        drv_d = drv_q;
        nack_d = nack_q;
        idx_d = idx_q;
        wr_d = 1'b0;
        store_d = store_q;
        if (start_ev) begin
            // start or repeated start restarts address phase [RQ6]
            phase_d = ST_ADDR;
            bit_d = `BIT_COUNT_ARMED; // the clock fall after a start is no data bit
            ack_d = 1'b0;
            drv_d = 1'b0;
            nack_d = 1'b0;
        end else if (stop_ev) begin
            phase_d = ST_IDLE; // [RQ13]
            ack_d = 1'b0;
            drv_d = 1'b0;
        end else if (phase_q != ST_IDLE) begin
            if (scl_rise) begin
                if (bit_q == `BIT_COUNT_ACK) begin
                    // master ack of read byte [RQ12]
                    if (rd_q && phase_q == ST_DATA) begin
                        nack_d = sda_lvl; // [RQ13]
                        // master ack moves the index before the next load [RQ14] [RQ17]
                        if (!sda_lvl) begin
                            idx_d = idx_q + 16'h0001;
                        end
                    end
                end else if (!drv_q) begin
                    // on a rise only a receiving engine shifts; a sending one keeps its byte until the fall
                    sh_d = shift_in(sh_q, sda_lvl); // [RQ3]
                end
            end else if (scl_fall) begin
                if (bit_q == `BIT_COUNT_LAST) begin
                    bit_d = `BIT_COUNT_ACK; // [RQ2]
                    drv_d = 1'b0;
                    case (phase_q)
                        ST_ADDR: begin
                            // address decode and direction [RQ7]
                            if (sh_q[7:1] == my_addr) begin
                                ack_d = 1'b1; // [RQ8]
                                rd_d = sh_q[0]; // [RQ8]
                            end else begin
                                phase_d = ST_IDLE;
                            end
                        end
                        ST_IDX_HI: begin
                            idx_d = {sh_q, idx_q[7:0]}; // [RQ9]
                            ack_d = 1'b1;
                        end
                        ST_IDX_LO: begin
                            idx_d = {idx_q[15:8], sh_q}; // [RQ9]
                            ack_d = 1'b1;
                        end
                        ST_DATA: begin
                            if (!rd_q) begin
                                ack_d = 1'b1; // [RQ10] [RQ12]
                                store_d = sh_q;
                            end
                        end
                        default: begin
                            phase_d = ST_IDLE;
                        end
                    endcase
                end else if (bit_q == `BIT_COUNT_ACK) begin
                    // end of ack slot, move on
                    ack_d = 1'b0;
                    bit_d = 4'h0;
                    case (phase_q)
                        ST_ADDR: begin
                            phase_d = rd_q ? ST_DATA : ST_IDX_HI;
                            if (rd_q) begin
                                // load indexed register [RQ11] [RQ17]
                                sh_d = rd_data;
                                drv_d = 1'b1;
                            end
                        end
                        ST_IDX_HI: phase_d = ST_IDX_LO;
                        ST_IDX_LO: phase_d = ST_DATA;
                        ST_DATA: begin
                            if (rd_q) begin
                                if (nack_q) begin
                                    phase_d = ST_IDLE; // [RQ13]
                                end else begin
                                    sh_d = rd_data; // index already advanced [RQ11]
                                    drv_d = 1'b1;
                                end
                            end else begin
                                // store then advance [RQ10] [RQ14] [RQ15] [RQ16]
                                wr_d = 1'b1;
                            end
                        end
                        default: phase_d = ST_IDLE;
                    endcase
                end else begin
                    bit_d = bit_q + 4'h1;
                    if (drv_q) begin
                        sh_d = {sh_q[6:0], 1'b0}; // next bit on fall [RQ11]
                    end
                end
            end
        end
        if (wr_q) begin
            idx_d = idx_q + 16'h0001; // [RQ14]
        end
    end

    // engine registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            nack_q <= 1'b0;
            idx_q <= 16'h0000;
            wr_q <= 1'b0;
            store_q <= 8'h00;
        end else begin
            phase_q <= phase_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            drv_q <= drv_d;
            nack_q <= nack_d;
            idx_q <= idx_d;
            wr_q <= wr_d;
            store_q <= store_d;
        end
    end

    // register array
    reg_store #(.DEPTH(DEPTH)) store (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_q),
        .index(idx_q),
        .wr_data(store_q),
        .rd_data(rd_data)
    );

    // open-drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = ack_q | (drv_q & ~sh_q[7]); // [RQ8] [RQ11]
    assign busy = (phase_q != ST_IDLE);
    assign wr_strobe = wr_q;
    assign cur_index = idx_q;

    // ack follows a matching address byte within one cycle of the eighth fall
    sequence addr_match_s;
        scl_fall && phase_q == ST_ADDR && bit_q == `BIT_COUNT_LAST
            && sh_q[7:1] == my_addr && !start_ev && !stop_ev;
    endsequence
    addr_ack_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ8]
        addr_match_s |=> sda_oe && ack_q)
        else $error("matching address not acknowledged");
    dir_latch_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
        addr_match_s |=> rd_q == $past(sh_q[0]))
        else $error("direction bit not latched");
    stop_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
        stop_ev && !start_ev |=> phase_q == ST_IDLE && !sda_oe)
        else $error("stop did not release the bus");
    start_addr_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ6]
        start_ev |=> phase_q == ST_ADDR && bit_q == `BIT_COUNT_ARMED)
        else $error("start did not open address phase");
    write_inc_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ14]
        wr_q |=> idx_q == $past(idx_q) + 16'h0001)
        else $error("index not incremented after write");
    store_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ10]
        wr_q |=> $past(rd_q) == 1'b0 && !wr_q)
        else $error("store pulse wrong");
    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13]
        phase_q == ST_IDLE |-> !drv_q)
        else $error("driving data while idle");
    ack_slot_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
        ack_q |-> bit_q == `BIT_COUNT_ACK)
        else $error("ack outside its slot");

    // a foreign address is refused and the engine falls idle
    sequence addr_miss_s;
        scl_fall && phase_q == ST_ADDR && bit_q == `BIT_COUNT_LAST
            && sh_q[7:1] != my_addr && !start_ev && !stop_ev;
    endsequence
    addr_refuse_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
        addr_miss_s |=> phase_q == ST_IDLE && !sda_oe)
        else $error("foreign address not refused");

    // a refused read byte ends the message as the ack slot closes
    nack_end_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13]
        scl_fall && bit_q == `BIT_COUNT_ACK && rd_q && phase_q == ST_DATA && nack_q
            && !start_ev && !stop_ev |=> phase_q == ST_IDLE && !sda_oe)
        else $error("refused read byte did not end the message");

    // read data loaded from the indexed register as the ack slot closes
    sequence read_load_s;
        scl_fall && bit_q == `BIT_COUNT_ACK && rd_q && !start_ev && !stop_ev
            && (phase_q == ST_ADDR || (phase_q == ST_DATA && !nack_q));
    endsequence
    read_load_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
        read_load_s |=> drv_q && sh_q == $past(rd_data))
        else $error("read byte not loaded");

    // a master-acknowledged read byte advances the index
    sequence master_ack_s;
        scl_rise && bit_q == `BIT_COUNT_ACK && rd_q && phase_q == ST_DATA
            && !sda_lvl && !start_ev && !stop_ev;
    endsequence
    read_inc_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ17]
        master_ack_s |=> idx_q == $past(idx_q) + 16'h0001)
        else $error("index not advanced after read byte");

    // our pull on the data line only moves while the clock is low
    hold_high_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
        scl_lvl && $past(scl_lvl) && !$past(start_ev) && !$past(stop_ev)
            |-> $stable(sda_oe))
        else $error("data line moved while clock high");
endmodule
`default_nettype wire

/* bus_master_model.sv */
// two-wire bus master model: drives scl and pulls sda low
// assumes the bench resolves sda with a pull-up and scl stands high when idle
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // two system clocks make one quarter of the 800 ns bit
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // start or repeated start, data falls while clock high
    task automatic start();
        sda_pull <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask
    // stop, data rises while clock high; only the master ends a message
    task automatic stop();
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_pull <= 1'b0;
        tick(4);
    endtask
    // one bit: data set while clock low, sampled late in the high phase
    task automatic bit_x(input logic b, output logic s);
        sda_pull <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(3);
        s = sda_line;
        tick(1);
        scl <= 1'b0;
        tick(2);
    endtask
    // byte out msb first, then release for the device's acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s; // burst goes on until a refusal or stop
    endtask
    // byte in, then the master's own acknowledge or refusal
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(~mack, s);
    endtask
endmodule
`default_nettype wire

/* i2c_indexed_register_slave_tb.sv */
// self-checking bench for the indexed-register two-wire slave
// assumes the map header, package, design modules and master model are compiled
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_map.svh"
module i2c_indexed_register_slave_tb;
    logic sys_clk, rst, addr_cfg_en, scl, sda_pull, sda_out, sda_oe, busy, wr_strobe, sda_line;
    logic [6:0] addr_cfg;
    logic [`INDEX_WIDTH-1:0] cur_index;
    int miscompares = 0, tests_run = 0, strobes = 0, cycles = 0;
    // open-drain line with pull-up
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
    i2c_reg_slave u_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_cfg_en(addr_cfg_en), .addr_cfg(addr_cfg),
        .busy(busy), .wr_strobe(wr_strobe), .cur_index(cur_index));
    bus_master_model u_mst (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));
    // 100 ns system clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // store pulses counted, hang cut short
    always @(posedge sys_clk) begin
        cycles++;
        if (wr_strobe === 1'b1) strobes++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    // send one byte and judge the device's acknowledge
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        u_mst.wr_byte(d, a);
        chk("slave_acknowledge", {15'h0000, exp_ack}, {15'h0000, a});
    endtask
    // finish the message and check the device went idle
    task automatic end_msg(input int exp_strobes, input int s0);
        u_mst.stop();
        repeat (4) @(posedge sys_clk);
        chk("busy", 16'h0000, {15'h0000, busy});
        chk("store pulses", exp_strobes[15:0], 16'(strobes - s0));
    endtask
    // burst write of three bytes at the default address
    task automatic write_burst();
        int s0;
        s0 = strobes;
        u_mst.start();
        send(8'h52, 1'b1);
        send(8'h00, 1'b1);
        send(8'h10, 1'b1);
        send(8'hA5, 1'b1);
        send(8'h3C, 1'b1);
        send(8'h7E, 1'b1);
        repeat (4) @(posedge sys_clk);
        chk("index after write", 16'h0013, cur_index);
        end_msg(3, s0);
    endtask
    // index set, repeated start, read back three bytes, last refused
    task automatic read_burst();
        logic [7:0] d;
        int s0;
        s0 = strobes;
        u_mst.start();
        send(8'h52, 1'b1);
        send(8'h00, 1'b1);
        send(8'h10, 1'b1);
        u_mst.start();
        send(8'h53, 1'b1);
        u_mst.rd_byte(1'b1, d);
        chk("read byte 0", 16'h00A5, {8'h00, d});
        u_mst.rd_byte(1'b1, d);
        chk("read byte 1", 16'h003C, {8'h00, d});
        u_mst.rd_byte(1'b0, d);
        chk("read byte 2", 16'h007E, {8'h00, d});
        chk("index after read", 16'h0012, cur_index);
        end_msg(0, s0);
    endtask
    // foreign address refused, then configured address replaces the default
    task automatic address_select();
        int s0;
        s0 = strobes;
        u_mst.start();
        send(8'h60, 1'b0);
        end_msg(0, s0);
        addr_cfg <= 7'h44;
        addr_cfg_en <= 1'b1;
        u_mst.start();
        send(8'h52, 1'b0);
        end_msg(0, s0);
        u_mst.start();
        send(8'h88, 1'b1);
        send(8'h01, 1'b1);
        send(8'h40, 1'b1);
        send(8'h5A, 1'b1);
        repeat (4) @(posedge sys_clk);
        chk("wide index", 16'h0141, cur_index);
        end_msg(1, s0);
        addr_cfg_en <= 1'b0;
    endtask
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        rst = 1'b1;
        addr_cfg_en = 1'b0;
        addr_cfg = 7'h00;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("index after reset", 16'h0000, cur_index);
        write_burst();
        read_burst();
        address_select();
        conclude();
    end
endmodule
`default_nettype wire
